// file: common/eip_pkg.sv
package eip_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int unsigned NUM_SRC = 4;
  localparam int unsigned ADDR_W  = 10;

  // ----------------------------------------------------------------
  // Register indices; byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_SOURCE_ENABLE = 8'he8;
  localparam logic [7:0] IDX_PRIO_HIGH     = 8'hf7;
  localparam logic [7:0] IDX_PRIO_LOW      = 8'hf8;
  localparam logic [7:0] IDX_EVENT_STATUS  = 8'hfa;
  localparam logic [7:0] IDX_EVENT_MASK    = 8'hfb;
  localparam logic [7:0] IDX_ARB_VIEW      = 8'hfc;
  localparam logic [7:0] IDX_RAW_VIEW      = 8'hfd;

  // ----------------------------------------------------------------
  // Field positions: source n sits at bit (SRC_FIELD_MSB - n)
  // ----------------------------------------------------------------
  localparam logic [2:0] BIT_EDGE      = 3'h7;
  localparam logic [2:0] BIT_UNDERFLOW = 3'h6;
  localparam logic [2:0] BIT_BRAKE     = 3'h5;
  localparam logic [2:0] BIT_WATCHDOG  = 3'h4;
  localparam logic [2:0] SRC_FIELD_MSB = BIT_EDGE;
  localparam logic [2:0] SRC_FIELD_LSB = BIT_WATCHDOG;
  localparam logic [2:0] VIEW_VALID_BIT = 3'h4;

  // Source numbers
  localparam logic [1:0] SRC_EDGE      = 2'h0;
  localparam logic [1:0] SRC_UNDERFLOW = 2'h1;
  localparam logic [1:0] SRC_BRAKE     = 2'h2;
  localparam logic [1:0] SRC_WATCHDOG  = 2'h3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] RST_ENABLE  = 4'h0;
  localparam logic [3:0] RST_PRIO_HI = 4'h0;
  localparam logic [3:0] RST_PRIO_LO = 4'h0;
  localparam logic [3:0] RST_MASK    = 4'h0;
  localparam logic [3:0] RST_STATUS  = 4'h0;

  // Avalon response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef logic [NUM_SRC-1:0] eip_srcvec_t;

  typedef struct packed {
    logic       valid;
    logic [1:0] source;
    logic [1:0] level;
  } eip_grant_t;

endpackage

// file: rtl/eip_event_capture.sv
`timescale 1ns/100ps
module eip_event_capture
(
  // Clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 rstn,
  // Raw request levels and software clear
  input  wire eip_pkg::eip_srcvec_t reqRaw,
  input  wire eip_pkg::eip_srcvec_t clearOnes,
  // Sticky event bits
  output      eip_pkg::eip_srcvec_t status
);

  typedef struct packed {
    eip_pkg::eip_srcvec_t prev;
    eip_pkg::eip_srcvec_t status;
  } eip_cap_state_t;

  eip_cap_state_t st_r;
  eip_cap_state_t st_nxt;

  // ----------------------------------------------------------------
  // Per source rising edge detect; a new event beats a clear
  // ----------------------------------------------------------------
  always_comb
  begin
    st_nxt      = st_r;
    st_nxt.prev = reqRaw;
    for (int i = 0; i < eip_pkg::NUM_SRC; i++)
    begin
      if (reqRaw[i] && !st_r.prev[i])
        st_nxt.status[i] = 1'b1;
      else if (clearOnes[i])
        st_nxt.status[i] = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_r.prev   <= '0;
      st_r.status <= eip_pkg::RST_STATUS;
    end
    else
      st_r <= st_nxt;
  end

  assign status = st_r.status;

endmodule

// file: rtl/eip_prio_arbiter.sv
`timescale 1ns/100ps
module eip_prio_arbiter
(
  // Gated requests and priority bits
  input  wire eip_pkg::eip_srcvec_t reqGated,
  input  wire eip_pkg::eip_srcvec_t prioHi,
  input  wire eip_pkg::eip_srcvec_t prioLo,
  // Winner
  output      eip_pkg::eip_grant_t  grant
);

  // ----------------------------------------------------------------
  // Highest two-bit level wins; equal levels go to the lower source
  // number, so edge detect beats watchdog at the same level
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [1:0] lvl;
    grant = '0;
    lvl   = 2'h0;
    for (int i = 0; i < eip_pkg::NUM_SRC; i++)
    begin
      lvl = {prioHi[i], prioLo[i]};
      if (reqGated[i] && (!grant.valid || lvl > grant.level))
      begin
        grant.valid  = 1'b1;
        grant.source = i[1:0];
        grant.level  = lvl;
      end
    end
  end

endmodule

// file: rtl/eip_irq_ctrl.sv
// The Avalon-MM interface to the registers was left to the implementer.
`timescale 1ns/100ps
module eip_irq_ctrl
#(
  parameter int unsigned ADDR_W = eip_pkg::ADDR_W
)
(
  // Clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 rstn,

  // Avalon-MM slave
  input  wire logic [ADDR_W-1:0]    address,
  input  wire logic                 read,
  input  wire logic                 write,
  input  wire logic [3:0]           byteenable,
  input  wire logic [31:0]          writedata,
  output      logic [31:0]          readdata,
  output      logic [1:0]           response,
  output      logic                 waitrequest,

  // Peripheral request levels, same clock domain
  input  wire logic                 edgeDetectReq,
  input  wire logic                 pwmUnderflowReq,
  input  wire logic                 brakeReq,
  input  wire logic                 watchdogReq,

  // Toward the CPU interrupt sequencer
  output      eip_pkg::eip_srcvec_t cpuPending,
  output      eip_pkg::eip_grant_t  cpuGrant,

  // Event interrupt
  output      logic                 irq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    eip_pkg::eip_srcvec_t enable;
    eip_pkg::eip_srcvec_t prioHi;
    eip_pkg::eip_srcvec_t prioLo;
    eip_pkg::eip_srcvec_t mask;
    logic                 waitReq;
    logic [7:0]           rdByte;
    logic [1:0]           resp;
    eip_pkg::eip_srcvec_t pending;
    eip_pkg::eip_grant_t  grant;
    logic                 irq;
  } eip_top_state_t;

  eip_top_state_t st_r;
  eip_top_state_t st_nxt;

  // ----------------------------------------------------------------
  // Request gathering
  // ----------------------------------------------------------------
  eip_pkg::eip_srcvec_t reqRaw;
  eip_pkg::eip_srcvec_t reqGated;
  eip_pkg::eip_srcvec_t status;
  eip_pkg::eip_srcvec_t clearOnes;
  eip_pkg::eip_grant_t  grantNow;

  always_comb
  begin
    reqRaw                          = '0;
    reqRaw[eip_pkg::SRC_EDGE]       = edgeDetectReq;
    reqRaw[eip_pkg::SRC_UNDERFLOW]  = pwmUnderflowReq;
    reqRaw[eip_pkg::SRC_BRAKE]      = brakeReq;
    reqRaw[eip_pkg::SRC_WATCHDOG]   = watchdogReq;
  end

  // Each source passes only while its enable bit is set
  always_comb
  begin
    reqGated = '0;
    reqGated[eip_pkg::SRC_EDGE] =
      reqRaw[eip_pkg::SRC_EDGE] && st_r.enable[eip_pkg::SRC_EDGE];
    reqGated[eip_pkg::SRC_UNDERFLOW] =
      reqRaw[eip_pkg::SRC_UNDERFLOW] && st_r.enable[eip_pkg::SRC_UNDERFLOW];
    reqGated[eip_pkg::SRC_BRAKE] =
      reqRaw[eip_pkg::SRC_BRAKE] && st_r.enable[eip_pkg::SRC_BRAKE];
    reqGated[eip_pkg::SRC_WATCHDOG] =
      reqRaw[eip_pkg::SRC_WATCHDOG] && st_r.enable[eip_pkg::SRC_WATCHDOG];
  end

  // ----------------------------------------------------------------
  // Sticky events and arbitration
  // ----------------------------------------------------------------
  eip_event_capture u_capture
  (
    .core_clk  (core_clk),
    .rstn      (rstn),
    .reqRaw    (reqRaw),
    .clearOnes (clearOnes),
    .status    (status)
  );

  eip_prio_arbiter u_arbiter
  (
    .reqGated (reqGated),
    .prioHi   (st_r.prioHi),
    .prioLo   (st_r.prioLo),
    .grant    (grantNow)
  );

  // ----------------------------------------------------------------
  // Field mapping between byte layout and source vector
  // ----------------------------------------------------------------
  function automatic eip_pkg::eip_srcvec_t field_to_src(input logic [7:0] b);
    eip_pkg::eip_srcvec_t v;
    v = '0;
    for (int i = 0; i < eip_pkg::NUM_SRC; i++)
      v[i] = b[eip_pkg::SRC_FIELD_MSB - i[2:0]];
    return v;
  endfunction

  // Reserved low nibble always reads back zero
  function automatic logic [7:0] src_to_field(input eip_pkg::eip_srcvec_t v);
    logic [7:0] b;
    b = 8'h00;
    for (int i = 0; i < eip_pkg::NUM_SRC; i++)
      b[eip_pkg::SRC_FIELD_MSB - i[2:0]] = v[i];
    return b;
  endfunction

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  logic       lowBits;
  logic [7:0] idx;
  logic       hitEnable;
  logic       hitPrioHi;
  logic       hitPrioLo;
  logic       hitStatus;
  logic       hitMask;
  logic       hitArbView;
  logic       hitRawView;
  logic       mapped;
  logic       wrAccept;
  logic       laneZero;
  logic [7:0] wrByte;

  always_comb
  begin
    lowBits    = |address[1:0];
    idx        = address[ADDR_W-1:2];
    hitEnable  = !lowBits && (idx == eip_pkg::IDX_SOURCE_ENABLE);
    hitPrioHi  = !lowBits && (idx == eip_pkg::IDX_PRIO_HIGH);
    hitPrioLo  = !lowBits && (idx == eip_pkg::IDX_PRIO_LOW);
    hitStatus  = !lowBits && (idx == eip_pkg::IDX_EVENT_STATUS);
    hitMask    = !lowBits && (idx == eip_pkg::IDX_EVENT_MASK);
    hitArbView = !lowBits && (idx == eip_pkg::IDX_ARB_VIEW);
    hitRawView = !lowBits && (idx == eip_pkg::IDX_RAW_VIEW);
    mapped     = hitEnable || hitPrioHi || hitPrioLo || hitStatus
              || hitMask || hitArbView || hitRawView;
    // A write lands only at the edge where waitrequest is seen low
    wrAccept   = write && !st_r.waitReq;
    laneZero   = byteenable[0];
    wrByte     = writedata[7:0];
  end

  // ----------------------------------------------------------------
  // Access strobes
  // ----------------------------------------------------------------
  logic accTaken;
  logic wrEnable;
  logic wrPrioHi;
  logic wrPrioLo;
  logic wrStatus;
  logic wrMask;

  // An access is taken at the first edge that sees it while idle; a
  // write with lane zero switched off is answered but changes nothing,
  // so the master never waits on a lane it did not enable
  always_comb
  begin
    accTaken = (read || write) && st_r.waitReq;
    wrEnable = wrAccept && laneZero && hitEnable;
    wrPrioHi = wrAccept && laneZero && hitPrioHi;
    wrPrioLo = wrAccept && laneZero && hitPrioLo;
    wrStatus = wrAccept && laneZero && hitStatus;
    wrMask   = wrAccept && laneZero && hitMask;
  end

  // Status clear pulses for write-one-to-clear
  always_comb
  begin
    clearOnes = '0;
    if (wrStatus)
      clearOnes = field_to_src(wrByte);
  end

  // ----------------------------------------------------------------
  // Read data selection
  // ----------------------------------------------------------------
  logic [7:0] arbView;
  logic [7:0] rdMux;

  // The view shows the registered grant, as the sequencer sees it
  always_comb
  begin
    arbView                          = 8'h00;
    arbView[eip_pkg::VIEW_VALID_BIT] = st_r.grant.valid;
    arbView[3:2]                     = st_r.grant.level;
    arbView[1:0]                     = st_r.grant.source;
  end

  // Unmapped and unaligned addresses read back zero
  always_comb
  begin
    rdMux = 8'h00;
    unique case (1'b1)
      hitEnable:  rdMux = src_to_field(st_r.enable);
      hitPrioHi:  rdMux = src_to_field(st_r.prioHi);
      hitPrioLo:  rdMux = src_to_field(st_r.prioLo);
      hitStatus:  rdMux = src_to_field(status);
      hitMask:    rdMux = src_to_field(st_r.mask);
      hitArbView: rdMux = arbView;
      hitRawView: rdMux = src_to_field(reqRaw);
      default:    rdMux = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // Bus answer
  // ----------------------------------------------------------------
  logic [1:0] respNow;
  logic [7:0] rdNow;

  // An unmapped access is still answered, with an error code, so a
  // stray address can never hang the master
  always_comb
  begin
    respNow = mapped ? eip_pkg::RESP_OKAY : eip_pkg::RESP_SLVERR;
    rdNow   = read ? rdMux : 8'h00;
  end

  // ----------------------------------------------------------------
  // Event interrupt
  // ----------------------------------------------------------------
  eip_pkg::eip_srcvec_t irqCause;
  logic                 irqNow;

  // Status bits are set whether or not the source is enabled; only
  // the mask decides whether they reach irq
  always_comb
  begin
    irqCause = status & st_r.mask;
    irqNow   = |irqCause;
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    st_nxt = st_r;

    // One wait cycle per access, then waitrequest drops for one cycle
    st_nxt.waitReq = !accTaken;

    // Answer is loaded at the taking edge and stands while waitrequest is low
    if (accTaken)
    begin
      st_nxt.resp   = respNow;
      st_nxt.rdByte = rdNow;
    end

    // Only bits 7-4 are stored, so bits 3-0 written have no effect
    if (wrEnable)
    begin
      st_nxt.enable = field_to_src(wrByte);
    end
    if (wrPrioHi)
    begin
      st_nxt.prioHi = field_to_src(wrByte);
    end
    if (wrPrioLo)
    begin
      st_nxt.prioLo = field_to_src(wrByte);
    end
    if (wrMask)
    begin
      st_nxt.mask = field_to_src(wrByte);
    end

    // Outputs toward the sequencer lag the sources by one cycle; pending
    // and grant move on the same edge, so a grant never names an idle source
    st_nxt.pending = reqGated;
    st_nxt.grant   = grantNow;
    st_nxt.irq     = irqNow;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Reset leaves every source masked at level zero
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_r.enable  <= eip_pkg::RST_ENABLE;
      st_r.prioHi  <= eip_pkg::RST_PRIO_HI;
      st_r.prioLo  <= eip_pkg::RST_PRIO_LO;
      st_r.mask    <= eip_pkg::RST_MASK;
      st_r.waitReq <= 1'b1;
      st_r.rdByte  <= 8'h00;
      st_r.resp    <= eip_pkg::RESP_OKAY;
      st_r.pending <= '0;
      st_r.grant   <= '0;
      st_r.irq     <= 1'b0;
    end
    else
      st_r <= st_nxt;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Every output is a register field, nothing combinational leaves
  assign readdata    = {24'h000000, st_r.rdByte};
  assign response    = st_r.resp;
  assign waitrequest = st_r.waitReq;
  assign cpuPending  = st_r.pending;
  assign cpuGrant    = st_r.grant;
  assign irq         = st_r.irq;

endmodule

// file: verif/eip_req_model.sv
`timescale 1ns/100ps
module eip_req_model
(
  // Clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 rstn,
  // Wanted levels, bit n is source n
  input  wire eip_pkg::eip_srcvec_t want,
  // Request lines
  output      logic                 edgeDetectReq,
  output      logic                 pwmUnderflowReq,
  output      logic                 brakeReq,
  output      logic                 watchdogReq
);
  // Sources move only on the clock, as in-domain peripherals do
  eip_pkg::eip_srcvec_t lvl_r;

  always_ff @(posedge core_clk or negedge rstn)
    if (!rstn)
      lvl_r <= 4'h0;
    else
      lvl_r <= want;

  assign {watchdogReq, brakeReq, pwmUnderflowReq, edgeDetectReq} = lvl_r;
endmodule

// file: verif/eip_irq_ctrl_assertions.sv
`timescale 1ns/100ps
module eip_irq_ctrl_chk
(
  // Clock and reset
  input wire logic                 core_clk,
  input wire logic                 rstn,
  // Bus handshake
  input wire logic                 read,
  input wire logic                 write,
  input wire logic                 waitrequest,
  // Requests and results
  input wire logic                 edgeDetectReq,
  input wire logic                 pwmUnderflowReq,
  input wire logic                 brakeReq,
  input wire logic                 watchdogReq,
  input wire eip_pkg::eip_srcvec_t cpuPending,
  input wire eip_pkg::eip_grant_t  cpuGrant,
  input wire logic                 irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);

  sequence s_answer;
    !waitrequest ##1 waitrequest;
  endsequence

  chk_wait_once: assert property ((read || write) && waitrequest |=> s_answer)
    else $error("bus answer not one cycle");
  chk_answer_cause: assert property ($fell(waitrequest) |-> $past(read || write))
    else $error("answer without request");
  chk_edge_gate: assert property (cpuPending[0] |-> $past(edgeDetectReq))
    else $error("edge pending without request");
  chk_under_gate: assert property (cpuPending[1] |-> $past(pwmUnderflowReq))
    else $error("underflow pending without request");
  chk_brake_gate: assert property (cpuPending[2] |-> $past(brakeReq))
    else $error("brake pending without request");
  chk_wdog_gate: assert property (cpuPending[3] |-> $past(watchdogReq))
    else $error("watchdog pending without request");
  chk_grant_any: assert property (cpuGrant.valid == (|cpuPending))
    else $error("grant valid disagrees with pending");
  chk_grant_src: assert property (cpuGrant.valid |-> cpuPending[cpuGrant.source])
    else $error("grant names idle source");
  chk_reset_clear: assert property ($rose(rstn) |-> (cpuPending == 4'h0 && !irq)[*2])
    else $error("outputs not clear after reset");
endmodule

bind eip_irq_ctrl eip_irq_ctrl_chk eip_irq_ctrl_chk_inst
(
  .core_clk(core_clk), .rstn(rstn), .read(read), .write(write),
  .waitrequest(waitrequest), .edgeDetectReq(edgeDetectReq),
  .pwmUnderflowReq(pwmUnderflowReq), .brakeReq(brakeReq),
  .watchdogReq(watchdogReq), .cpuPending(cpuPending),
  .cpuGrant(cpuGrant), .irq(irq)
);

// file: verif/eip_irq_ctrl_tb_top.sv
`timescale 1ns/100ps
module eip_irq_ctrl_tb_top;
  logic                 core_clk = 1'b0;
  logic                 rstn = 1'b0;
  logic [9:0]           address;
  logic                 read;
  logic                 write;
  logic [3:0]           byteenable;
  logic [31:0]          writedata;
  logic [31:0]          readdata;
  logic [1:0]           response;
  logic                 waitrequest;
  logic                 edReq;
  logic                 ufReq;
  logic                 bkReq;
  logic                 wdReq;
  eip_pkg::eip_srcvec_t want;
  eip_pkg::eip_srcvec_t cpuPending;
  eip_pkg::eip_grant_t  cpuGrant;
  logic                 irq;
  logic [31:0]          rdVal;
  logic [1:0]           respVal;
  int                   bad_count = 0;
  int                   samples_checked = 0;

  always #4 core_clk = ~core_clk;

  eip_req_model eip_req_model_inst
  (
    .core_clk(core_clk), .rstn(rstn), .want(want), .edgeDetectReq(edReq),
    .pwmUnderflowReq(ufReq), .brakeReq(bkReq), .watchdogReq(wdReq)
  );

  eip_irq_ctrl eip_irq_ctrl_inst
  (
    .core_clk(core_clk), .rstn(rstn), .address(address), .read(read),
    .write(write), .byteenable(byteenable), .writedata(writedata),
    .readdata(readdata), .response(response), .waitrequest(waitrequest),
    .edgeDetectReq(edReq), .pwmUnderflowReq(ufReq), .brakeReq(bkReq),
    .watchdogReq(wdReq), .cpuPending(cpuPending), .cpuGrant(cpuGrant), .irq(irq)
  );

  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Starts one edge on so a release and a new request never share a time step
  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    @(posedge core_clk);
    address <= {idx, 2'h0};
    write <= wr;
    read <= !wr;
    writedata <= {24'h0, wd};
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (waitrequest !== 1'b0 && n < 20);
    if (n >= 20)
    begin
      bad_count++;
      finish_test();
    end
    rdVal = readdata;
    respVal = response;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp, input string what);
    xfer(1'b0, idx, 8'h00);
    check(what, {24'h0, exp}, rdVal);
    check("response", {30'h0, eip_pkg::RESP_OKAY}, 32'(respVal));
  endtask

  // Request model plus registered outputs need two edges; one spare
  task automatic settle;
    repeat (3) @(posedge core_clk);
  endtask

  task automatic t_reset;
    check("pending", 32'h0, 32'(cpuPending));
    rd_chk(eip_pkg::IDX_SOURCE_ENABLE, 8'h00, "enable");
    rd_chk(eip_pkg::IDX_PRIO_HIGH, 8'h00, "prio high");
    rd_chk(eip_pkg::IDX_PRIO_LOW, 8'h00, "prio low");
    $display("reset test done");
  endtask

  task automatic t_enable;
    want <= 4'hf;
    for (int s = 0; s < 4; s++)
    begin
      xfer(1'b1, eip_pkg::IDX_SOURCE_ENABLE, 8'h80 >> s);
      settle();
      check("pending one", 32'(4'h1 << s), 32'(cpuPending));
    end
    xfer(1'b1, eip_pkg::IDX_SOURCE_ENABLE, 8'hff);
    rd_chk(eip_pkg::IDX_SOURCE_ENABLE, 8'hf0, "enable reserved");
    check("pending all", 32'hf, 32'(cpuPending));
    $display("enable test done");
  endtask

  task automatic t_prio;
    logic [7:0] b;
    logic [7:0] o;
    logic [1:0] src;
    for (int s = 0; s < 4; s++)
    begin
      b = 8'h80 >> s;
      o = 8'h80 >> ((s + 1) % 4);
      src = s[1:0];
      xfer(1'b1, eip_pkg::IDX_PRIO_HIGH, b);
      xfer(1'b1, eip_pkg::IDX_PRIO_LOW, o);
      settle();
      check("grant two", {27'h0, 1'b1, src, 2'h2}, 32'(cpuGrant));
      xfer(1'b1, eip_pkg::IDX_PRIO_LOW, b | o);
      settle();
      check("grant three", {27'h0, 1'b1, src, 2'h3}, 32'(cpuGrant));
      xfer(1'b1, eip_pkg::IDX_PRIO_HIGH, 8'h0f);
      xfer(1'b1, eip_pkg::IDX_PRIO_LOW, b);
      settle();
      check("grant one", {27'h0, 1'b1, src, 2'h1}, 32'(cpuGrant));
    end
    rd_chk(eip_pkg::IDX_PRIO_HIGH, 8'h00, "prio reserved");
    xfer(1'b1, eip_pkg::IDX_PRIO_LOW, 8'h0f);
    settle();
    check("grant tie", {27'h0, 1'b1, 4'h0}, 32'(cpuGrant));
    rd_chk(eip_pkg::IDX_ARB_VIEW, 8'h10, "arbiter view");
    $display("priority test done");
  endtask

  task automatic t_irq;
    want <= 4'h0;
    settle();
    xfer(1'b1, eip_pkg::IDX_EVENT_STATUS, 8'hf0);
    rd_chk(eip_pkg::IDX_EVENT_STATUS, 8'h00, "status clear");
    want <= 4'h4;
    settle();
    rd_chk(eip_pkg::IDX_EVENT_STATUS, 8'h20, "status set");
    rd_chk(eip_pkg::IDX_RAW_VIEW, 8'h20, "raw view");
    check("irq masked", 32'h0, 32'(irq));
    xfer(1'b1, eip_pkg::IDX_EVENT_MASK, 8'h20);
    settle();
    check("irq raised", 32'h1, 32'(irq));
    xfer(1'b1, eip_pkg::IDX_EVENT_STATUS, 8'h20);
    settle();
    check("irq cleared", 32'h0, 32'(irq));
    xfer(1'b0, 8'h00, 8'h00);
    check("unmapped response", {30'h0, eip_pkg::RESP_SLVERR}, 32'(respVal));
    check("unmapped data", 32'h0, rdVal);
    $display("interrupt test done");
  endtask

  // Lane zero off must not write; a reset in mid-run must clear grant, irq, enable and both priority registers
  task automatic t_reset_mid;
    byteenable <= 4'h0;
    xfer(1'b1, eip_pkg::IDX_PRIO_HIGH, 8'hf0);
    byteenable <= 4'hf;
    rd_chk(eip_pkg::IDX_PRIO_HIGH, 8'h00, "lane off");
    xfer(1'b1, eip_pkg::IDX_PRIO_HIGH, 8'hf0);
    xfer(1'b1, eip_pkg::IDX_PRIO_LOW, 8'hf0);
    rd_chk(eip_pkg::IDX_PRIO_HIGH, 8'hf0, "prio high set");
    rstn <= 1'b0;
    repeat (4) @(posedge core_clk);
    rstn <= 1'b1;
    check("grant", 32'h0, 32'(cpuGrant));
    check("irq", 32'h0, 32'(irq));
    rd_chk(eip_pkg::IDX_SOURCE_ENABLE, 8'h00, "enable");
    rd_chk(eip_pkg::IDX_PRIO_HIGH, 8'h00, "prio high");
    rd_chk(eip_pkg::IDX_PRIO_LOW, 8'h00, "prio low");
    $display("mid-run reset test done");
  endtask

  initial
  begin
    address = 10'h0;
    read = 1'b0;
    write = 1'b0;
    byteenable = 4'hf;
    writedata = 32'h0;
    want = 4'h0;
    repeat (16) @(posedge core_clk);
    rstn <= 1'b1;
    t_reset();
    t_enable();
    t_prio();
    t_irq();
    t_reset_mid();
    finish_test();
  end

  initial
  begin
    repeat (20000) @(posedge core_clk);
    bad_count++;
    finish_test();
  end
endmodule
